/* File: src/crs_clock_ref_ctrl.sv */
module crs_clock_ref_ctrl
  import crs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog side
  input  wire logic        core_regulator_ok,
  input  wire crs_trim_s   factory_trim,
  input  wire crs_cal_t    factory_cal,
  output logic             core_reset_n,
  output logic             pll_enable,
  output logic             fast_rc_enable,
  output logic             slow_rc_enable,
  output logic             bandgap_enable,
  output logic             pll_ready,
  output logic             bandgap_ready,
  output logic             sys_clk_from_pll,
  output logic [3:0]       pll_mult,
  output logic [1:0]       adc_clk_div,
  output crs_trim_s        trim_out,
  output crs_cal_t         cal_out,
  output logic             slow_tick
);

  typedef struct packed {
    crs_ctrl_s   ctrl;
    crs_trim_s   trim;
    crs_cal_t    cal;
    logic        aw_got;
    logic        w_got;
    logic [11:0] waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [8:0]  div_cnt;
    logic        tick;
    logic        on_pll;
    logic        rst_out_n;
  } crs_state_s;

  crs_state_s s_reg;
  crs_state_s s_next;
  logic       rst_n;
  logic       pll_settled;
  logic       bg_settled;
  logic       pll_ok;
  logic [4:0] status;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic is_cal(input logic [11:0] a);
    return (a >= OFF_CAL_FIRST) && (a <= OFF_CAL_LAST);
  endfunction : is_cal

  function automatic logic [1:0] cal_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - OFF_CAL_FIRST;
    return d[3:2];
  endfunction : cal_idx

  // Misaligned or past the map: DECERR, nothing touched
  function automatic logic bad_addr(input logic [11:0] a);
    return (a > OFF_LAST) || (a[1:0] != 2'b00);
  endfunction : bad_addr

  // Control and trim fields live in byte lane 0 only
  function automatic logic lane0_hit(input logic [11:0] a,
                                     input logic [3:0]  strb,
                                     input logic [11:0] off);
    return (a == off) && strb[0];
  endfunction : lane0_hit

  // Unused bits and unassigned words read 0
  function automatic logic [31:0] read_word(input crs_state_s  st,
                                            input logic [4:0]  stat,
                                            input logic [11:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == OFF_CTRL) begin
      w[3:0] = st.ctrl;
    end else if (a == OFF_STATUS) begin
      w[4:0] = stat;
    end else if (a == OFF_LDO_TRIM) begin
      w[LDO_TRIM_W-1:0] = st.trim.core_regulator_trim;
    end else if (a == OFF_SLOW_TRIM) begin
      w[SLOW_TRIM_W-1:0] = st.trim.slow_rc_trim;
    end else if (a == OFF_FAST_TRIM) begin
      w[FAST_TRIM_W-1:0] = st.trim.fast_rc_trim;
    end else if (is_cal(a)) begin
      w = st.cal[cal_idx(a)];
    end
    return w;
  endfunction : read_word

  // ----------------------------------------------------------------
  // Reset and settle timers
  // ----------------------------------------------------------------
  assign rst_n = aresetn && core_regulator_ok;

  crs_settle_timer #(
    .TICKS    (8'(PLL_SETTLE_TICKS)),
    .EN_RESET (PLL_ON_RESET)
  ) u_pll_timer (
    .aclk      (aclk),
    .rst_n     (rst_n),
    .enable    (s_reg.ctrl.pll_power_on),
    .slow_tick (s_reg.tick),
    .ready     (pll_settled)
  );

  crs_settle_timer #(
    .TICKS    (8'(BG_SETTLE_TICKS)),
    .EN_RESET (!BG_PD_RESET)
  ) u_bg_timer (
    .aclk      (aclk),
    .rst_n     (rst_n),
    .enable    (!s_reg.ctrl.bandgap_power_down),
    .slow_tick (s_reg.tick),
    .ready     (bg_settled)
  );

  // PLL locks to the fast RC, which itself leans on the bandgap
  assign pll_ok = pll_settled && bg_settled && !s_reg.ctrl.fast_rc_power_down;

  // Slow RC bit fixed high: nothing can stop it
  assign status = {s_reg.on_pll, 1'b1, !s_reg.ctrl.fast_rc_power_down, bg_settled, pll_ok};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;

    // Slow oscillator tick, never gated
    s_next.tick = 1'b0;
    if (s_reg.div_cnt == SLOW_DIV_LAST) begin
      s_next.div_cnt = 9'h000;
      s_next.tick    = 1'b1;
    end else begin
      s_next.div_cnt = s_reg.div_cnt + 9'h001;
    end

    // Switch to PLL only once settled; 4 MHz x mult stays within 48 MHz
    s_next.on_pll    = s_reg.ctrl.clk_sel && pll_ok;
    s_next.rst_out_n = 1'b1;

    // Write channel capture
    // Address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_got = 1'b1;
      s_next.waddr  = s_axi_awaddr[11:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    // Write commit
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = RESP_OKAY;
      if (bad_addr(s_reg.waddr)) begin
        s_next.bresp = RESP_DECERR;
      end else if (lane0_hit(s_reg.waddr, s_reg.wstrb, OFF_CTRL)) begin
        s_next.ctrl.pll_power_on       = s_reg.wdata[CTRL_PLL_ON_BIT];
        s_next.ctrl.fast_rc_power_down = s_reg.wdata[CTRL_RC_PD_BIT];
        s_next.ctrl.bandgap_power_down = s_reg.wdata[CTRL_BG_PD_BIT];
        s_next.ctrl.clk_sel            = s_reg.wdata[CTRL_CLK_SEL_BIT];
      end else if (lane0_hit(s_reg.waddr, s_reg.wstrb, OFF_LDO_TRIM)) begin
        s_next.trim.core_regulator_trim = s_reg.wdata[LDO_TRIM_W-1:0];
      end else if (lane0_hit(s_reg.waddr, s_reg.wstrb, OFF_SLOW_TRIM)) begin
        s_next.trim.slow_rc_trim = s_reg.wdata[SLOW_TRIM_W-1:0];
      end else if (lane0_hit(s_reg.waddr, s_reg.wstrb, OFF_FAST_TRIM)) begin
        s_next.trim.fast_rc_trim = s_reg.wdata[FAST_TRIM_W-1:0];
      end else if (is_cal(s_reg.waddr)) begin
        s_next.cal[cal_idx(s_reg.waddr)] =
          merge(s_reg.cal[cal_idx(s_reg.waddr)], s_reg.wdata, s_reg.wstrb);
      end
      // Other in-range locations hold nothing: writes dropped
    end

    // Read
    // Answer stands from the edge after the address is taken
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = RESP_OKAY;
      s_next.rdata  = 32'h0000_0000;
      if (bad_addr(s_axi_araddr[11:0])) begin
        s_next.rresp = RESP_DECERR;
      end else begin
        s_next.rdata = read_word(s_reg, status, s_axi_araddr[11:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      s_reg           <= '0;
      s_reg.ctrl      <= '{clk_sel:            CLK_SEL_RESET,
                           bandgap_power_down: BG_PD_RESET,
                           fast_rc_power_down: RC_PD_RESET,
                           pll_power_on:       PLL_ON_RESET};
      // Trims reload from factory values on every reset
      s_reg.trim      <= factory_trim;
      s_reg.cal       <= factory_cal;
      s_reg.rst_out_n <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready    = !s_reg.aw_got && !s_reg.bvalid;
  assign s_axi_wready     = !s_reg.w_got && !s_reg.bvalid;
  assign s_axi_bvalid     = s_reg.bvalid;
  assign s_axi_bresp      = s_reg.bresp;
  assign s_axi_arready    = !s_reg.rvalid;
  assign s_axi_rvalid     = s_reg.rvalid;
  assign s_axi_rdata      = s_reg.rdata;
  assign s_axi_rresp      = s_reg.rresp;
  assign core_reset_n     = s_reg.rst_out_n;
  assign pll_enable       = s_reg.ctrl.pll_power_on;
  assign fast_rc_enable   = !s_reg.ctrl.fast_rc_power_down;
  assign slow_rc_enable   = 1'b1;
  assign bandgap_enable   = !s_reg.ctrl.bandgap_power_down;
  assign pll_ready        = pll_ok;
  assign bandgap_ready    = bg_settled;
  assign sys_clk_from_pll = s_reg.on_pll;
  assign pll_mult         = PLL_MULT;
  assign adc_clk_div      = ADC_CLK_DIV;
  assign trim_out         = s_reg.trim;
  assign cal_out          = s_reg.cal;
  assign slow_tick        = s_reg.tick;

endmodule : crs_clock_ref_ctrl

/* File: src/crs_pkg.sv */
package crs_pkg;

  // ----------------------------------------------------------------
  // Clock rates and settling times
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ      = 20_000_000;
  localparam int SLOW_RC_HZ      = 64_000;
  localparam int SLOW_DIV        = SYS_CLK_HZ / SLOW_RC_HZ;
  localparam int SLOW_PERIOD_NS  = 1_000_000_000 / SLOW_RC_HZ;
  localparam int PLL_SETTLE_NS   = 6000;
  localparam int BG_SETTLE_NS    = 2000;
  // Extra tick: phase of the first slow tick after enable is unknown
  localparam int PLL_SETTLE_TICKS =
    (PLL_SETTLE_NS + SLOW_PERIOD_NS - 1) / SLOW_PERIOD_NS + 1;
  localparam int BG_SETTLE_TICKS  =
    (BG_SETTLE_NS + SLOW_PERIOD_NS - 1) / SLOW_PERIOD_NS + 1;
  localparam logic [8:0] SLOW_DIV_LAST = 9'(SLOW_DIV - 1);

  // ----------------------------------------------------------------
  // Clock tree figures
  // ----------------------------------------------------------------
  localparam int FAST_RC_HZ     = 4_000_000;
  localparam int SYS_CLK_MAX_HZ = 48_000_000;
  localparam int ADC_CLK_HZ     = 24_000_000;
  localparam logic [3:0] PLL_MULT    = 4'(SYS_CLK_MAX_HZ / FAST_RC_HZ);
  localparam logic [1:0] ADC_CLK_DIV = 2'(SYS_CLK_MAX_HZ / ADC_CLK_HZ);

  // ----------------------------------------------------------------
  // Register offsets (low 12 address bits)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_STATUS    = 12'h004;
  localparam logic [11:0] OFF_LDO_TRIM  = 12'h010;
  localparam logic [11:0] OFF_SLOW_TRIM = 12'h014;
  localparam logic [11:0] OFF_FAST_TRIM = 12'h018;
  localparam logic [11:0] OFF_CAL_FIRST = 12'h01C;
  localparam logic [11:0] OFF_CAL_LAST  = 12'h028;
  localparam logic [11:0] OFF_LAST      = 12'h03C;
  localparam int          CAL_WORDS     = 4;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int CTRL_PLL_ON_BIT  = 0;
  localparam int CTRL_RC_PD_BIT   = 1;
  localparam int CTRL_BG_PD_BIT   = 2;
  localparam int CTRL_CLK_SEL_BIT = 3;
  localparam int ST_PLL_RDY_BIT   = 0;
  localparam int ST_BG_RDY_BIT    = 1;
  localparam int ST_RC_RUN_BIT    = 2;
  localparam int ST_SLOW_RUN_BIT  = 3;
  localparam int ST_ON_PLL_BIT    = 4;
  localparam int LDO_TRIM_W       = 3;
  localparam int SLOW_TRIM_W      = 4;
  localparam int FAST_TRIM_W      = 6;

  // ----------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic        PLL_ON_RESET  = 1'b0;
  localparam logic        RC_PD_RESET   = 1'b0;
  localparam logic        BG_PD_RESET   = 1'b0;
  localparam logic        CLK_SEL_RESET = 1'b0;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_DECERR   = 2'b11;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic clk_sel;
    logic bandgap_power_down;
    logic fast_rc_power_down;
    logic pll_power_on;
  } crs_ctrl_s;

  typedef struct packed {
    logic [LDO_TRIM_W-1:0]  core_regulator_trim;
    logic [SLOW_TRIM_W-1:0] slow_rc_trim;
    logic [FAST_TRIM_W-1:0] fast_rc_trim;
  } crs_trim_s;

  typedef logic [CAL_WORDS-1:0][31:0] crs_cal_t;

  typedef enum logic [2:0] {
    TMR_OFF   = 3'b001,
    TMR_WAIT  = 3'b010,
    TMR_READY = 3'b100
  } crs_tmr_e;

endpackage : crs_pkg

/* File: src/crs_settle_timer.sv */
module crs_settle_timer
  import crs_pkg::*;
#(
  parameter logic [7:0] TICKS    = 8'h01,
  parameter logic       EN_RESET = 1'b0
) (
  input  wire logic aclk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic slow_tick,
  output logic      ready
);

  typedef struct packed {
    crs_tmr_e   st;
    logic       en_q;
    logic [7:0] cnt;
  } crs_tmr_s;

  crs_tmr_s t_reg;
  crs_tmr_s t_next;

  // ----------------------------------------------------------------
  // Settle counter on the slow oscillator tick
  // ----------------------------------------------------------------
  always_comb begin
    t_next      = t_reg;
    t_next.en_q = enable;
    case (t_reg.st)
      TMR_OFF: begin
        if (enable) begin
          t_next.st  = TMR_WAIT;
          t_next.cnt = 8'h00;
        end
      end
      TMR_WAIT: begin
        if (slow_tick) begin
          t_next.cnt = t_reg.cnt + 8'h01;
          if (t_reg.cnt + 8'h01 >= TICKS) begin
            t_next.st = TMR_READY;
          end
        end
      end
      TMR_READY: begin
      end
      default: begin
        t_next.st = TMR_OFF;
      end
    endcase
    // Any change restarts the wait; disable drops ready one clock after enable falls
    if (enable != t_reg.en_q) begin
      t_next.st  = enable ? TMR_WAIT : TMR_OFF;
      t_next.cnt = 8'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      t_reg.st   <= EN_RESET ? TMR_WAIT : TMR_OFF;
      t_reg.en_q <= EN_RESET;
      t_reg.cnt  <= 8'h00;
    end else begin
      t_reg <= t_next;
    end
  end

  assign ready = (t_reg.st == TMR_READY) && t_reg.en_q;

endmodule : crs_settle_timer

/* File: verif/crs_clock_ref_ctrl_chk.sv */
module crs_clock_ref_ctrl_chk
  import crs_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       core_regulator_ok,
  input wire logic       core_reset_n,
  input wire logic       pll_enable,
  input wire logic       fast_rc_enable,
  input wire logic       slow_rc_enable,
  input wire logic       bandgap_enable,
  input wire logic       pll_ready,
  input wire logic       bandgap_ready,
  input wire logic       sys_clk_from_pll,
  input wire logic [3:0] pll_mult,
  input wire logic [1:0] adc_clk_div,
  input wire logic       s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Cycles since the PLL and bandgap enables rose
  // ----------------------------------------
  // Count lags one cycle, so ready may linger in the cycle an enable drops
  localparam logic [9:0] PLL_MIN = 10'(PLL_SETTLE_NS / 50);
  localparam logic [9:0] BG_MIN  = 10'(BG_SETTLE_NS / 50);
  typedef struct packed {
    logic [9:0] pll;
    logic [9:0] bg;
  } crs_chk_s;
  crs_chk_s cnt_reg;
  crs_chk_s cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (!pll_enable) begin
      cnt_next.pll = '0;
    end else if (cnt_reg.pll != 10'h3FF) begin
      cnt_next.pll = cnt_reg.pll + 10'h001;
    end
    if (!bandgap_enable) begin
      cnt_next.bg = '0;
    end else if (cnt_reg.bg != 10'h3FF) begin
      cnt_next.bg = cnt_reg.bg + 10'h001;
    end
    if (!aresetn || !core_regulator_ok) begin
      cnt_next = '0;
    end
  end

  always_ff @(posedge aclk) begin
    cnt_reg <= cnt_next;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking

  pll_off_reset_a : assert property (!aresetn |=> !pll_enable)
    else $error("pll powered after reset");
  rc_on_reset_a : assert property (!aresetn |=> fast_rc_enable)
    else $error("fast rc stopped after reset");
  slow_run_a : assert property (slow_rc_enable == 1'b1)
    else $error("slow rc stopped");
  bg_on_reset_a : assert property (!aresetn |=> bandgap_enable && !bandgap_ready)
    else $error("bandgap state wrong after reset");
  pll_settle_a : assert property (disable iff (!aresetn) pll_ready |-> cnt_reg.pll >= PLL_MIN)
    else $error("pll ready too early");
  bg_settle_a : assert property (disable iff (!aresetn) bandgap_ready |-> cnt_reg.bg >= BG_MIN)
    else $error("bandgap ready too early");
  bg_drop_a : assert property (disable iff (!aresetn) $fell(bandgap_enable) |=> !bandgap_ready)
    else $error("bandgap ready kept after disable");
  por_hold_a : assert property ((!aresetn || !core_regulator_ok) |=> !core_reset_n && !pll_enable)
    else $error("core not held in reset");
  sys_clk_a : assert property (disable iff (!aresetn) sys_clk_from_pll |-> $past(pll_ready))
    else $error("pll clock selected before ready");
  clk_ratio_a : assert property (pll_mult == 4'hC && adc_clk_div == 2'h2)
    else $error("clock ratios wrong");

  cover property ($rose(pll_ready));
  cover property ($fell(bandgap_enable));
  cover property (s_axi_bvalid && s_axi_bresp == RESP_DECERR);
  cover property ($rose(sys_clk_from_pll));
endmodule : crs_clock_ref_ctrl_chk

bind crs_clock_ref_ctrl crs_clock_ref_ctrl_chk i_crs_clock_ref_ctrl_chk (
  .aclk, .aresetn, .core_regulator_ok, .core_reset_n, .pll_enable, .fast_rc_enable,
  .slow_rc_enable, .bandgap_enable, .pll_ready, .bandgap_ready, .sys_clk_from_pll,
  .pll_mult, .adc_clk_div, .s_axi_bvalid, .s_axi_bresp
);

/* File: verif/tb_crs_clock_ref_ctrl.sv */
module tb_crs_clock_ref_ctrl
  import crs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        aclk              = 1'b0;
  logic        aresetn           = 1'b0;
  logic        core_regulator_ok = 1'b1;
  logic [31:0] s_axi_awaddr      = '0;
  logic [31:0] s_axi_wdata       = '0;
  logic [31:0] s_axi_araddr      = '0;
  logic [3:0]  s_axi_wstrb       = '0;
  logic        s_axi_awvalid     = 1'b0;
  logic        s_axi_wvalid      = 1'b0;
  logic        s_axi_bready      = 1'b0;
  logic        s_axi_arvalid     = 1'b0;
  logic        s_axi_rready      = 1'b0;
  crs_trim_s   factory_trim      = {3'h5, 4'hA, 6'h2C};
  crs_cal_t    factory_cal       = {32'h0C0A_0003, 32'h0C0A_0002, 32'h0C0A_0001, 32'h0C0A_0000};
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, adc_clk_div;
  logic [31:0] s_axi_rdata;
  logic        core_reset_n, pll_enable, fast_rc_enable, slow_rc_enable, bandgap_enable;
  logic        pll_ready, bandgap_ready, sys_clk_from_pll, slow_tick;
  logic [3:0]  pll_mult;
  crs_trim_s   trim_out;
  crs_cal_t    cal_out;
  logic [11:0] resv [4]          = '{12'h008, 12'h00C, 12'h02C, 12'h03C};
  int          failures          = 0;
  int          check_count       = 0;
  int          n;

  always #25 aclk = ~aclk;

  crs_clock_ref_ctrl i_crs_clock_ref_ctrl (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .core_regulator_ok, .factory_trim, .factory_cal,
    .core_reset_n, .pll_enable, .fast_rc_enable, .slow_rc_enable, .bandgap_enable,
    .pll_ready, .bandgap_ready, .sys_clk_from_pll, .pll_mult, .adc_clk_div, .trim_out,
    .cal_out, .slow_tick
  );

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Ready is judged at the falling edge, so no race with the design's own edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= {20'h40000, a};
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk(32'(r), 32'(er), "write response");
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic ar, v;
    logic [1:0] r;
    logic [31:0] d;
    @(posedge aclk);
    s_axi_araddr <= {20'h40000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      r = s_axi_rresp;
      d = s_axi_rdata;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(32'(r), 32'(er), "read response");
    if (er == RESP_OKAY) chk(d, exp, "read data");
  endtask : rd

  task automatic wt(input logic pll);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while ((pll ? pll_ready : bandgap_ready) !== 1'b1 && n < 2000);
  endtask : wt

  task automatic summarize();
    $display("failures=%0d checks=%0d", failures, check_count);
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #1_000_000;
    failures++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(32'({pll_enable, fast_rc_enable, bandgap_enable}), 32'h3, "enables");
    chk(32'(slow_rc_enable), 32'h1, "slow rc");
    rd(OFF_CTRL, 32'h0, RESP_OKAY);
    rd(OFF_LDO_TRIM, 32'(factory_trim.core_regulator_trim), RESP_OKAY);
    rd(OFF_SLOW_TRIM, 32'(factory_trim.slow_rc_trim), RESP_OKAY);
    rd(OFF_FAST_TRIM, 32'(factory_trim.fast_rc_trim), RESP_OKAY);
    for (int i = 0; i < CAL_WORDS; i++) begin
      rd(OFF_CAL_FIRST + 12'(4 * i), factory_cal[i], RESP_OKAY);
    end
    chk(cal_out[3], factory_cal[3], "cal out");
    wr(OFF_CAL_FIRST, 32'h1234_5678, 4'h3, RESP_OKAY);
    rd(OFF_CAL_FIRST, {factory_cal[0][31:16], 16'h5678}, RESP_OKAY);
    foreach (resv[i]) begin
      wr(resv[i], 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
      rd(resv[i], 32'h0, RESP_OKAY);
    end
    wr(12'h040, 32'h1, 4'hF, RESP_DECERR);
    rd(12'h002, 32'h0, RESP_DECERR);
    wr(OFF_SLOW_TRIM, 32'h3, 4'h1, RESP_OKAY);
    rd(OFF_SLOW_TRIM, 32'h3, RESP_OKAY);
    chk(32'(trim_out.slow_rc_trim), 32'h3, "slow trim out");
    wr(OFF_CTRL, 32'h1, 4'h0, RESP_OKAY);
    chk(32'(pll_enable), 32'h0, "ctrl write without strobe");
    wt(1'b0);
    rd(OFF_STATUS, 32'h0E, RESP_OKAY);
    wr(OFF_CTRL, 32'h9, 4'h1, RESP_OKAY);
    chk(32'(pll_enable), 32'h1, "pll on");
    wt(1'b1);
    chk(32'(n >= PLL_SETTLE_NS / 50 - 3 && n < 1000), 32'h1, "pll settle");
    repeat (2) @(negedge aclk);
    chk(32'(sys_clk_from_pll), 32'h1, "pll clock selected");
    rd(OFF_STATUS, 32'h1F, RESP_OKAY);
    chk(32'({pll_mult, adc_clk_div}), 32'h32, "clock ratios");
    wr(OFF_CTRL, 32'hB, 4'h1, RESP_OKAY);
    chk(32'({fast_rc_enable, pll_ready}), 32'h0, "fast rc stopped");
    rd(OFF_STATUS, 32'h0A, RESP_OKAY);
    wr(OFF_CTRL, 32'h4, 4'h1, RESP_OKAY);
    @(negedge aclk);
    chk(32'({bandgap_enable, bandgap_ready}), 32'h0, "bandgap off");
    wr(OFF_CTRL, 32'h0, 4'h1, RESP_OKAY);
    wt(1'b0);
    chk(32'(n >= BG_SETTLE_NS / 50 - 3 && n < 1000), 32'h1, "bandgap settle");
    n = 0;
    while (slow_tick !== 1'b1 && n < 1000) begin
      @(negedge aclk);
      n++;
    end
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (slow_tick !== 1'b1 && n < 1000);
    chk(32'(n), 32'(SLOW_DIV), "slow tick period");
    wr(OFF_CTRL, 32'h1, 4'h1, RESP_OKAY);
    core_regulator_ok <= 1'b0;
    repeat (3) @(negedge aclk);
    chk(32'({core_reset_n, pll_enable}), 32'h0, "held in reset");
    @(posedge aclk);
    core_regulator_ok <= 1'b1;
    @(negedge aclk);
    chk(32'({trim_out, pll_enable}), 32'({factory_trim, 1'b0}), "reload");
    chk(cal_out[0], factory_cal[0], "cal reload");
    @(negedge aclk);
    chk(32'(core_reset_n), 32'h1, "reset released");
    summarize();
  end
endmodule : tb_crs_clock_ref_ctrl
